// ==== logic/cwhb_pkg.sv ====
// Package for the channel word handshake bridge: widths, status and maintenance bit positions, timing.
// Assumes a single system clock at 10 MHz.
package cwhb_pkg;
	localparam int          CWHB_CLK_NS        = 100;
	localparam int          CWHB_STROBE_DLY_NS = 50;
	localparam int          CWHB_STROBE_DLY_CY = (CWHB_STROBE_DLY_NS + CWHB_CLK_NS - 1) / CWHB_CLK_NS;
	localparam int          CWHB_CLR_PULSE_NS  = 50;
	localparam int          CWHB_CLR_PULSE_CY  = (CWHB_CLR_PULSE_NS + CWHB_CLK_NS - 1) / CWHB_CLK_NS;
	localparam int          CWHB_WORD_W        = 32;
	localparam int          CWHB_CHAN_W        = 3;
	localparam int          CWHB_STAT_W        = 8;
	localparam int          CWHB_MAINT_W       = 9;
	localparam int          CWHB_FIFO_DEPTH    = 8;
	// Status bit positions
	localparam int          ST_MAINT           = 0;
	localparam int          ST_OUT_EN          = 1;
	localparam int          ST_CMD_PRES        = 2;
	localparam int          ST_DATA_PRES       = 3;
	localparam int          ST_LATCH_N         = 4;
	localparam int          ST_LATCH_M         = 5;
	localparam int          ST_READ_PRES       = 6;
	localparam int          ST_MAINT2          = 7;
	// Maintenance register bit positions
	localparam int          MC_INH_OVR         = 0;
	localparam int          MC_MAINT           = 1;
	localparam int          MC_CHAN_ERR        = 2;
	localparam int          MC_INTR            = 3;
	localparam int          MC_SRV_REQ         = 4;
	localparam int          MC_NORM_RX         = 5;
	localparam int          MC_MAINT_RX        = 6;
	localparam int          MC_CLR_PRES        = 7;
	localparam int          MC_MAINT2          = 8;
	localparam logic [8:0]  MAINT_RESET        = 9'h000;
	localparam logic [31:0] WORD_RESET         = 32'h0000_0000;
	typedef enum logic [1:0] {CWHB_CMD_WAIT, CWHB_CMD_SAMPLE, CWHB_CMD_HOLD, CWHB_CMD_TAIL} cwhb_cmd_e;
endpackage

// ==== logic/cwhb_fifo.sv ====
// Small FIFO carrying peripheral read words toward the input register.
// Assumes one clock; push and pop use valid/ready.
`timescale 1ns/1ps
`default_nettype none
module cwhb_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
)(
	input  wire logic             sys_clk_in,
	input  wire logic             rstn_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;
	assign push          = in_valid_in && (cnt_q != (AW+1)'(DEPTH));
	assign pop           = out_valid_out && out_ready_in;
	assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = mem_q[rd_q];
	always_ff @(posedge sys_clk_in)
	begin
		if (push)
			mem_q[wr_q] <= in_data_in;
	end
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			// Wrap explicitly so non power of two depths work
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // cwhb_fifo
`default_nettype wire

// ==== logic/cwhb_bridge.sv ====
// Channel word handshake bridge: host strobe bus to peripheral present/latch handshake.
// Assumes host strobes and peripheral lines are synchronous to sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module cwhb_bridge
	import cwhb_pkg::*;
#(
	parameter logic [CWHB_CHAN_W-1:0] CHAN_ADDR = 3'h0,
	parameter int                     DLY_CY    = CWHB_STROBE_DLY_CY,
	parameter int                     PULSE_CY  = CWHB_CLR_PULSE_CY
)(
	input  wire logic                   sys_clk_in,
	input  wire logic                   rstn_in,
	input  wire logic [CWHB_CHAN_W-1:0] chan_addr_in,
	input  wire logic [CWHB_WORD_W-1:0] host_data_in,
	input  wire logic                   write_data_cmd_in,
	input  wire logic                   write_command_address_cmd_in,
	input  wire logic                   read_data_cmd_in,
	input  wire logic                   read_status_cmd_in,
	input  wire logic                   clear_error_cmd_in,
	input  wire logic                   read_interrupt_cmd_in,
	input  wire logic                   read_service_request_cmd_in,
	input  wire logic                   interrupt_acknowledge_in,
	input  wire logic                   error_acknowledge_in,
	input  wire logic                   service_request_acknowledge_in,
	input  wire logic                   load_maint_cmd_in,
	input  wire logic                   offline_block_in,
	input  wire logic                   millisecond_mark_in,
	output logic [CWHB_WORD_W-1:0]      host_data_out,
	output logic [3:0]                  host_parity_out,
	output logic                        ready_out,
	output logic                        maint_response_out,
	output logic                        all_seems_well_out,
	output logic                        interrupt_out,
	output logic                        service_request_out,
	output logic                        channel_error_out,
	output logic [CWHB_WORD_W-1:0]      periph_data_out,
	output logic                        data_present_flag_out,
	output logic                        command_present_flag_out,
	output logic                        read_present_flag_out,
	output logic                        periph_inhibit_out,
	output logic                        periph_ms_mark_out,
	input  wire logic                   clear_output_present_in,
	input  wire logic [CWHB_WORD_W-1:0] periph_data_in,
	input  wire logic                   latch_input_norm_in,
	input  wire logic                   latch_input_maint_in,
	input  wire logic                   periph_interrupt_in,
	input  wire logic                   periph_service_request_in,
	input  wire logic                   periph_channel_error_in
);
	typedef struct packed {
		cwhb_cmd_e               st;
		logic [7:0]              dly;
		logic                    is_rd;
		logic                    is_addr;
		logic                    ok;
		logic [CWHB_WORD_W-1:0]  out_word;
		logic [CWHB_WORD_W-1:0]  in_word;
		logic                    word_pres;
		logic                    addr_pres;
		logic                    ln;
		logic                    lm;
		logic                    rpf;
		logic                    intr;
		logic                    srq;
		logic                    cerr;
		logic [CWHB_MAINT_W-1:0] maint;
		logic                    prev_cmd;
		logic                    prev_read_interrupt_cmd;
		logic                    prev_rsr;
		logic                    prev_off;
		logic                    prev_ln;
		logic                    prev_lm;
		logic                    lat_maint;
		logic                    rdy;
		logic                    mresp;
		logic                    well;
		logic [CWHB_WORD_W-1:0]  hdata;
		logic                    bus_int;
		logic                    bus_srq;
		logic                    bus_cerr;
		logic                    inh;
		logic                    msm;
	} cwhb_state_s;

	cwhb_state_s s_q;
	cwhb_state_s s_d;
	logic        sel;
	logic        cmd_any;
	logic        fifo_in_ready;
	logic        fifo_valid;
	logic        fifo_pop;
	logic [CWHB_WORD_W-1:0] fifo_data;
	logic        latch_evt;

	function automatic logic [CWHB_STAT_W-1:0] status_word(input cwhb_state_s s, input logic inh);
		logic [CWHB_STAT_W-1:0] v;
		v               = '0;
		v[ST_MAINT]     = s.maint[MC_MAINT];
		v[ST_OUT_EN]    = !inh || s.maint[MC_INH_OVR];
		v[ST_CMD_PRES]  = s.addr_pres;
		v[ST_DATA_PRES] = s.word_pres;
		v[ST_LATCH_N]   = s.ln;
		v[ST_LATCH_M]   = s.lm;
		v[ST_READ_PRES] = s.ln || s.lm;
		v[ST_MAINT2]    = s.maint[MC_MAINT2];
		return v;
	endfunction

	assign sel     = (chan_addr_in == CHAN_ADDR);
	assign cmd_any = sel && (write_data_cmd_in || write_command_address_cmd_in || read_data_cmd_in);
	// Latched words queue in the FIFO; peripheral holding rules keep it near empty
	assign latch_evt = (latch_input_norm_in && !s_q.prev_ln) || (latch_input_maint_in && !s_q.prev_lm);

	cwhb_fifo #(
		.WIDTH (CWHB_WORD_W),
		.DEPTH (CWHB_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (latch_evt),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (periph_data_in),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_pop),
		.out_data_out  (fifo_data)
	);
	// Input register refills only once the host has drained it
	assign fifo_pop = fifo_valid && !s_q.ln && !s_q.lm && s_q.st == CWHB_CMD_WAIT;

	always_comb
	begin
		s_d           = s_q;
		s_d.prev_cmd  = cmd_any;
		s_d.prev_read_interrupt_cmd = sel && read_interrupt_cmd_in;
		s_d.prev_rsr  = sel && read_service_request_cmd_in;
		s_d.prev_off  = offline_block_in;
		s_d.prev_ln   = latch_input_norm_in;
		s_d.prev_lm   = latch_input_maint_in;
		// Which latch line a queued word arrived on
		if (latch_evt && fifo_in_ready)
			s_d.lat_maint = latch_input_maint_in && !s_q.prev_lm;
		if (fifo_pop)
		begin
			s_d.in_word = fifo_data;
			if (s_q.lat_maint)
				s_d.lm = 1'b1;
			else
				s_d.ln = 1'b1;
			s_d.rpf = 1'b1;
		end
		// Command sequencer: sample after delay, act on trailing edge
		unique case (s_q.st)
			CWHB_CMD_WAIT:
			begin
				if (cmd_any && !s_q.prev_cmd)
				begin
					s_d.st     = CWHB_CMD_SAMPLE;
					s_d.dly     = 8'(DLY_CY);
					s_d.is_rd   = read_data_cmd_in;
					s_d.is_addr = write_command_address_cmd_in;
					if (!read_data_cmd_in && !s_q.word_pres && !s_q.addr_pres)
						s_d.out_word = host_data_in;
				end
			end
			CWHB_CMD_SAMPLE:
			begin
				if (s_q.dly > 8'h01)
					s_d.dly = s_q.dly - 8'h01;
				else
				begin
					s_d.st = CWHB_CMD_HOLD;
					s_d.ok = s_q.is_rd ? (s_q.ln || s_q.lm) : (!s_q.word_pres && !s_q.addr_pres);
				end
			end
			CWHB_CMD_HOLD:
			begin
				if (!cmd_any)
				begin
					s_d.st  = CWHB_CMD_TAIL;
					s_d.dly = 8'(PULSE_CY);
					if (s_q.ok && !s_q.is_rd)
					begin
						s_d.word_pres = !s_q.is_addr;
						s_d.addr_pres = s_q.is_addr;
					end
					if (s_q.ok && s_q.is_rd)
					begin
						s_d.ln = 1'b0;
						s_d.lm = 1'b0;
					end
				end
			end
			CWHB_CMD_TAIL:
			begin
				// Clear pulse width before the next command is accepted
				if (s_q.dly > 8'h01)
					s_d.dly = s_q.dly - 8'h01;
				else
				begin
					s_d.st = CWHB_CMD_WAIT;
					s_d.ok = 1'b0;
					if (s_q.ok && s_q.is_rd)
						s_d.rpf = 1'b0;
				end
			end
		endcase
		if (clear_output_present_in)
		begin
			s_d.word_pres = 1'b0;
			s_d.addr_pres = 1'b0;
			s_d.out_word = WORD_RESET;
		end
		// Peripheral events, masked in maintenance state
		if (!s_q.maint[MC_MAINT])
		begin
			s_d.intr = s_q.intr || periph_interrupt_in;
			s_d.srq  = s_q.srq || periph_service_request_in;
			s_d.cerr = s_q.cerr || periph_channel_error_in;
		end
		// Read-and-clear on trailing edge; a same-cycle set still wins
		if (s_q.prev_read_interrupt_cmd && !(sel && read_interrupt_cmd_in))
			s_d.intr = !s_q.maint[MC_MAINT] && periph_interrupt_in;
		if (s_q.prev_rsr && !(sel && read_service_request_cmd_in))
			s_d.srq = !s_q.maint[MC_MAINT] && periph_service_request_in;
		if (sel && load_maint_cmd_in)
		begin
			s_d.maint = host_data_in[CWHB_MAINT_W-1:0];
			if (host_data_in[MC_CHAN_ERR])
				s_d.cerr = 1'b1;
			if (host_data_in[MC_INTR])
				s_d.intr = 1'b1;
			if (host_data_in[MC_SRV_REQ])
				s_d.srq = 1'b1;
			if (host_data_in[MC_NORM_RX])
			begin
				s_d.ln  = 1'b1;
				s_d.rpf = 1'b1;
			end
			if (host_data_in[MC_MAINT_RX])
			begin
				s_d.lm  = 1'b1;
				s_d.rpf = 1'b1;
			end
			if (host_data_in[MC_CLR_PRES])
			begin
				s_d.word_pres = 1'b0;
				s_d.addr_pres = 1'b0;
			end
		end
		if (sel && clear_error_cmd_in)
		begin
			s_d.st    = CWHB_CMD_WAIT;
			s_d.ok    = 1'b0;
			s_d.word_pres = 1'b0;
			s_d.addr_pres = 1'b0;
			s_d.ln    = 1'b0;
			s_d.lm    = 1'b0;
			s_d.rpf   = 1'b0;
			s_d.cerr  = 1'b0;
			s_d.maint = MAINT_RESET;
			s_d.maint[MC_MAINT] = s_q.maint[MC_MAINT];
		end
		if (offline_block_in && !s_q.prev_off)
			s_d.maint = MAINT_RESET;
		// Registered host responses
		s_d.rdy      = 1'b0;
		s_d.mresp    = 1'b0;
		s_d.well     = 1'b0;
		s_d.hdata    = WORD_RESET;
		if (s_q.st == CWHB_CMD_HOLD && s_q.ok)
			s_d.rdy = 1'b1;
		if (s_q.st == CWHB_CMD_HOLD && s_q.ok && s_q.is_rd)
		begin
			s_d.hdata = s_q.in_word;
			s_d.mresp = s_q.lm;
			s_d.well  = s_q.ln;
		end
		if (sel && (read_status_cmd_in || clear_error_cmd_in || read_interrupt_cmd_in
			|| read_service_request_cmd_in || load_maint_cmd_in
			|| interrupt_acknowledge_in || error_acknowledge_in || service_request_acknowledge_in))
		begin
			s_d.rdy = 1'b1;
			s_d.well = 1'b1;
		end
		if (sel && read_status_cmd_in)
			s_d.hdata = {24'h00_0000, status_word(s_q, offline_block_in)};
		if (sel && (read_interrupt_cmd_in || interrupt_acknowledge_in))
			s_d.hdata[0] = s_q.intr;
		if (sel && read_service_request_cmd_in)
			s_d.hdata[0] = s_q.srq;
		if (sel && service_request_acknowledge_in)
			s_d.hdata[CHAN_ADDR] = s_q.srq;
		if (sel && error_acknowledge_in)
			s_d.hdata[CHAN_ADDR] = s_q.cerr;
		s_d.bus_int  = s_q.intr;
		s_d.bus_srq  = s_q.srq;
		s_d.bus_cerr = s_q.cerr;
		s_d.inh      = (offline_block_in && !s_q.maint[MC_INH_OVR]) || s_q.maint[MC_MAINT];
		s_d.msm      = millisecond_mark_in;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_q       <= '0;
			s_q.st    <= CWHB_CMD_WAIT;
			s_q.maint <= MAINT_RESET;
		end
		else
			s_q <= s_d;
	end

	// Parity not carried on this bus; status replies need zero parity anyway
	assign host_parity_out          = 4'h0;
	assign host_data_out            = s_q.hdata;
	assign ready_out                = s_q.rdy;
	assign maint_response_out       = s_q.mresp;
	assign all_seems_well_out       = s_q.well;
	assign interrupt_out            = s_q.bus_int;
	assign service_request_out      = s_q.bus_srq;
	assign channel_error_out        = s_q.bus_cerr;
	assign periph_data_out          = s_q.out_word;
	assign data_present_flag_out    = s_q.word_pres;
	assign command_present_flag_out = s_q.addr_pres;
	assign read_present_flag_out    = s_q.rpf;
	assign periph_inhibit_out       = s_q.inh;
	assign periph_ms_mark_out       = s_q.msm;
endmodule // cwhb_bridge
`default_nettype wire

// ==== testbench/cwhb_bridge_chk.sv ====
// Checker for the channel word handshake bridge, watching top-level ports only.
// Assumes one clock domain and the async active-low reset of the bridge.
`timescale 1ns/1ps
`default_nettype none
module cwhb_bridge_chk
	import cwhb_pkg::*;
#(
	parameter logic [CWHB_CHAN_W-1:0] CHAN_ADDR = 3'h0
)(
	input wire logic                   sys_clk_in,
	input wire logic                   rstn_in,
	input wire logic [CWHB_CHAN_W-1:0] chan_addr_in,
	input wire logic                   write_data_cmd_in,
	input wire logic                   read_data_cmd_in,
	input wire logic                   interrupt_acknowledge_in,
	input wire logic                   clear_output_present_in,
	input wire logic                   latch_input_norm_in,
	input wire logic                   latch_input_maint_in,
	input wire logic [3:0]             host_parity_out,
	input wire logic                   ready_out,
	input wire logic                   maint_response_out,
	input wire logic                   all_seems_well_out,
	input wire logic                   data_present_flag_out,
	input wire logic                   command_present_flag_out,
	input wire logic                   read_present_flag_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	wire logic sel = (chan_addr_in == CHAN_ADDR);
	wire logic pres = data_present_flag_out || command_present_flag_out;
	sequence wr_go;
		$rose(write_data_cmd_in) && sel && !pres ##1 write_data_cmd_in [*3];
	endsequence
	sequence wr_done;
		write_data_cmd_in && ready_out ##1 !write_data_cmd_in;
	endsequence
	sequence rd_done;
		read_data_cmd_in && ready_out ##1 !read_data_cmd_in;
	endsequence
	wr_ready_a: assert property (wr_go |-> ##[0:1] ready_out) else $error("write not answered");
	wr_refuse_a: assert property ($rose(write_data_cmd_in) && pres |-> !ready_out [*4])
		else $error("refused write answered");
	wr_flag_a: assert property (wr_done |-> ##[0:2] data_present_flag_out) else $error("data present not set");
	clr_drop_a: assert property ($rose(clear_output_present_in) |-> ##[1:2] !pres)
		else $error("present flags not cleared");
	sel_gate_a: assert property ($rose(write_data_cmd_in) && !sel |-> !ready_out [*4])
		else $error("foreign address answered");
	latch_rp_a: assert property ($rose(latch_input_norm_in || latch_input_maint_in) |-> ##[1:4] read_present_flag_out)
		else $error("read present not raised");
	rd_noready_a: assert property ($rose(read_data_cmd_in) && !read_present_flag_out |-> !ready_out [*4])
		else $error("empty read answered");
	rd_resp_a: assert property (read_data_cmd_in && ready_out |-> maint_response_out ^ all_seems_well_out)
		else $error("read response lines wrong");
	rp_fall_a: assert property (rd_done |-> ##[1:5] !read_present_flag_out)
		else $error("read present not dropped");
	ack_ready_a: assert property ($rose(interrupt_acknowledge_in) && sel |-> ##[1:2] ready_out)
		else $error("acknowledge not answered");
	par_zero_a: assert property (host_parity_out == 4'h0) else $error("parity not zero");
endmodule // cwhb_bridge_chk
`default_nettype wire

// ==== testbench/cwhb_periph_model.sv ====
// Peripheral model: takes output words, sends words through the latch lines.
// Assumes the bridge's present and read-present flags; bench calls send().
`timescale 1ns/1ps
`default_nettype none
module cwhb_periph_model
	import cwhb_pkg::*;
(
	input  wire logic                   sys_clk_in,
	input  wire logic                   rstn_in,
	input  wire logic                   accept_en_in,
	input  wire logic [CWHB_WORD_W-1:0] out_word_in,
	input  wire logic                   data_present_in,
	input  wire logic                   command_present_in,
	input  wire logic                   read_present_in,
	output logic                        clear_present_out,
	output logic      [CWHB_WORD_W-1:0] word_out,
	output logic                        latch_norm_out,
	output logic                        latch_maint_out,
	output logic      [CWHB_WORD_W-1:0] taken_out
);
	logic busy_q;
	// Busy blocks a second pulse while the flags are still falling
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			clear_present_out <= 1'b0;
			busy_q <= 1'b0;
			taken_out <= 32'h0000_0000;
		end
		else
		begin
			clear_present_out <= 1'b0;
			if (clear_present_out)
				busy_q <= 1'b1;
			else if (!(data_present_in || command_present_in))
				busy_q <= 1'b0;
			if (accept_en_in && (data_present_in || command_present_in) && !busy_q && !clear_present_out)
			begin
				taken_out <= out_word_in;
				clear_present_out <= 1'b1;
			end
		end
	end
	initial
	begin
		word_out = 32'h0000_0000;
		latch_norm_out = 1'b0;
		latch_maint_out = 1'b0;
	end
	task automatic send(input logic [31:0] w, input logic m);
		int n;
		n = 0;
		while (read_present_in && n < 50)
		begin
			@(posedge sys_clk_in);
			n++;
		end
		@(posedge sys_clk_in);
		#1 word_out = w;
		@(posedge sys_clk_in);
		#1 latch_norm_out = !m;
		latch_maint_out = m;
		repeat (2) @(posedge sys_clk_in);
		#1 latch_norm_out = 1'b0;
		latch_maint_out = 1'b0;
		// Released lines show the inverse, not the stale word
		word_out = ~w;
	endtask
endmodule // cwhb_periph_model
`default_nettype wire

// ==== testbench/cwhb_bridge_bench.sv ====
// Self-checking bench for the bridge: host strobe tasks plus a peripheral model.
// Assumes a 10 MHz clock and the default one-cycle delay counts.
`timescale 1ns/1ps
`default_nettype none
module cwhb_bridge_bench;
	import cwhb_pkg::*;
	localparam logic [2:0] CH = 3'h2;
	localparam int OP_WR = 0, OP_WC = 1, OP_RD = 2, OP_ST = 3, OP_CE = 4, OP_RI = 5, OP_RS = 6, OP_LM = 10;
	logic        sys_clk_in, rstn_in, ready, mresp, wellr, intr, srq, cer, dpres, cpres, rp, msm, msmo;
	logic        off, pi, ps, pe, acc, clrp, ln, lm, inh;
	logic [10:0] cv;
	logic [2:0]  ca, f;
	logic [31:0] hd, pdo, pdi, hdo, taken, d;
	int          num_errors, n_compared, i;
	cwhb_bridge #(.CHAN_ADDR(CH)) DUT (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .chan_addr_in(ca), .host_data_in(hd),
		.write_data_cmd_in(cv[0]), .write_command_address_cmd_in(cv[1]), .read_data_cmd_in(cv[2]),
		.read_status_cmd_in(cv[3]), .clear_error_cmd_in(cv[4]), .read_interrupt_cmd_in(cv[5]),
		.read_service_request_cmd_in(cv[6]), .interrupt_acknowledge_in(cv[7]), .error_acknowledge_in(cv[8]),
		.service_request_acknowledge_in(cv[9]), .load_maint_cmd_in(cv[10]), .offline_block_in(off),
		.millisecond_mark_in(msm), .host_data_out(hdo), .host_parity_out(), .ready_out(ready),
		.maint_response_out(mresp), .all_seems_well_out(wellr), .interrupt_out(intr), .service_request_out(srq),
		.channel_error_out(cer), .periph_data_out(pdo), .data_present_flag_out(dpres),
		.command_present_flag_out(cpres), .read_present_flag_out(rp), .periph_inhibit_out(inh),
		.periph_ms_mark_out(msmo), .clear_output_present_in(clrp), .periph_data_in(pdi),
		.latch_input_norm_in(ln), .latch_input_maint_in(lm), .periph_interrupt_in(pi),
		.periph_service_request_in(ps), .periph_channel_error_in(pe));
	cwhb_periph_model u_pd (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .accept_en_in(acc), .out_word_in(pdo),
		.data_present_in(dpres), .command_present_in(cpres), .read_present_in(rp), .clear_present_out(clrp),
		.word_out(pdi), .latch_norm_out(ln), .latch_maint_out(lm), .taken_out(taken));
	always #50 sys_clk_in = ~sys_clk_in;
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	// Strobe held five cycles, answer taken before release, then a quiet gap
	task automatic cmd(input int c, input logic [31:0] w);
		@(posedge sys_clk_in);
		#1 hd = w;
		cv[c] = 1'b1;
		repeat (5) @(posedge sys_clk_in);
		#1 f = {ready, mresp, wellr};
		d = hdo;
		cv[c] = 1'b0;
		repeat (5) @(posedge sys_clk_in);
	endtask
	task automatic wait_cy(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge sys_clk_in);
		num_errors++;
		complete_run;
	end
	initial
	begin
		{sys_clk_in, rstn_in, msm, off, pi, ps, pe, acc} = '0;
		cv = '0;
		ca = CH;
		hd = '0;
		num_errors = 0;
		n_compared = 0;
		wait_cy(5);
		rstn_in = 1'b1;
		wait_cy(1);
		cmd(OP_ST, 0); chk("reset status", d[7:0] & 8'hFD, 8'h00);
		chk("inhibit idle", inh, 1'b0);
		cmd(OP_WR, 32'hA5C3_0F1E); chk("write ready", f[2], 1'b1);
		chk("out word", pdo, 32'hA5C3_0F1E);
		chk("data present", {cpres, dpres}, 2'b01);
		cmd(OP_ST, 0); chk("status data flag", d[7:0] & 8'hFD, 8'h08);
		cmd(OP_WR, 32'h1234_5678); chk("write refused", f[2], 1'b0);
		chk("out word held", pdo, 32'hA5C3_0F1E);
		acc = 1'b1;
		wait_cy(6);
		acc = 1'b0;
		chk("word taken", taken, 32'hA5C3_0F1E);
		chk("flags cleared", {cpres, dpres}, 2'b00);
		cmd(OP_WC, 32'hFFFF_0001); chk("addr write ready", f[2], 1'b1);
		chk("cmd present", {cpres, dpres}, 2'b10);
		cmd(OP_ST, 0); chk("status cmd flag", d[7:0] & 8'hFD, 8'h04);
		acc = 1'b1;
		wait_cy(6);
		acc = 1'b0;
		chk("cmd taken", taken, 32'hFFFF_0001);
		ca = 3'h5;
		cmd(OP_WR, 32'h0BAD_0BAD); chk("foreign write", {f[2], dpres}, 2'b00);
		msm = 1'b1;
		wait_cy(3);
		chk("ms mark", msmo, 1'b1);
		msm = 1'b0;
		ca = CH;
		$display("test write done");
		cmd(OP_RD, 0); chk("empty read", {f[2], rp}, 2'b00);
		u_pd.send(32'hC0DE_0042, 1'b0);
		wait_cy(4);
		chk("read present", rp, 1'b1);
		cmd(OP_ST, 0); chk("status latch n", d[7:0] & 8'hFD, 8'h50);
		cmd(OP_RD, 0); chk("rd resp n", f, 3'b101);
		chk("rd word", d, 32'hC0DE_0042);
		chk("rp dropped", rp, 1'b0);
		cmd(OP_ST, 0); chk("status after rd", d[7:0] & 8'hFD, 8'h00);
		u_pd.send(32'h7E57_9ABC, 1'b1);
		wait_cy(4);
		cmd(OP_ST, 0); chk("status latch m", d[7:0] & 8'hFD, 8'h60);
		cmd(OP_RD, 0); chk("rd resp m", f, 3'b110);
		chk("rd word m", d, 32'h7E57_9ABC);
		$display("test read done");
		{pi, ps, pe} = 3'b111;
		wait_cy(2);
		{pi, ps, pe} = 3'b000;
		wait_cy(2);
		chk("event flags", {intr, srq, cer}, 3'b111);
		cmd(OP_RI, 0); chk("int read bit", d[0], 1'b1);
		cmd(OP_RS, 0); chk("srq read bit", d[0], 1'b1);
		cmd(OP_CE, 0); chk("event flags cleared", {intr, srq, cer}, 3'b000);
		for (i = 7; i < 10; i++)
		begin
			cmd(i, 0); chk("ack ready", f[2], 1'b1);
		end
		$display("test events done");
		cmd(OP_WR, 32'h0000_0055);
		cmd(OP_LM, 32'h0000_0080); chk("maint clears data flag", dpres, 1'b0);
		cmd(OP_LM, 32'h0000_0102);
		cmd(OP_ST, 0); chk("maint bits", d[7:0] & 8'h81, 8'h81);
		chk("inhibit in maint", inh, 1'b1);
		pi = 1'b1;
		wait_cy(3);
		pi = 1'b0;
		chk("maint ignores int", intr, 1'b0);
		cmd(OP_CE, 0);
		cmd(OP_ST, 0); chk("clear keeps maint", d[7:0] & 8'h81, 8'h01);
		off = 1'b1;
		wait_cy(3);
		cmd(OP_ST, 0); chk("offline clears", d[0], 1'b0);
		off = 1'b0;
		$display("test maintenance done");
		complete_run;
	end
endmodule // cwhb_bridge_bench
bind cwhb_bridge cwhb_bridge_chk #(.CHAN_ADDR(CHAN_ADDR)) u_chk (.sys_clk_in, .rstn_in, .chan_addr_in,
	.write_data_cmd_in, .read_data_cmd_in, .interrupt_acknowledge_in, .clear_output_present_in,
	.latch_input_norm_in, .latch_input_maint_in, .host_parity_out, .ready_out, .maint_response_out,
	.all_seems_well_out, .data_present_flag_out, .command_present_flag_out, .read_present_flag_out);
`default_nettype wire
